// File: rtl/asd_defines.svh
// register map, field positions and reset values of the audio frame decoder
`ifndef ASD_DEFINES_SVH
`define ASD_DEFINES_SVH

// register byte offsets on the apb bus
`define ASD_OFF_CTRL       12'h000
`define ASD_OFF_LEN        12'h004
`define ASD_OFF_STAT       12'h008
`define ASD_OFF_DATA       12'h00C

// control register fields
`define ASD_CTRL_EN        0
`define ASD_CTRL_VAR_LO    1
`define ASD_CTRL_WS_INV    3
`define ASD_CTRL_FALL      4
`define ASD_CTRL_ACT_LOW   5
`define ASD_CTRL_LSB       6
`define ASD_CTRL_RIGHT1ST  7
`define ASD_CTRL_NCH_LO    8
`define ASD_CTRL_MASK      32'h0000_07FF
`define ASD_CTRL_RST       32'h0000_0100

// length register fields, six bits each
`define ASD_LEN_FW         6
`define ASD_LEN_CLEN_LO    0
`define ASD_LEN_WLEN_LO    8
`define ASD_LEN_OFF_LO     16
`define ASD_LEN_DLY_LO     24
`define ASD_LEN_RST        32'h0000_1020
`define ASD_SLOT_MAX       6'h20

// status register fields
`define ASD_STAT_ALIGNED   0
`define ASD_STAT_NEW       1
`define ASD_STAT_CHAN_LO   4
`define ASD_STAT_FIRST     7
`define ASD_STAT_CNT_LO    16

`endif

// File: rtl/asd_pkg.sv
// types shared by the audio frame decoder
package asd_pkg;

  // protocol variant as held in the control register
  typedef enum logic [1:0] {
    asd_i2s_format,
    asd_left_aligned_format,
    asd_right_aligned_format,
    asd_tdm_format
  } asd_variant_t;

  // alignment state of the slot tracker
  typedef enum logic [1:0] {
    asd_st_unaligned,
    asd_st_active,
    asd_st_done
  } asd_state_t;

  // decoded configuration
  typedef struct packed {
    logic         enable;
    asd_variant_t variant;
    logic         ws_inv;
    logic         sample_fall;
    logic         act_low;
    logic         lsb_first;
    logic         right_first;
    logic [2:0]   nch_m1;
    logic [5:0]   clen;
    logic [5:0]   wlen;
    logic [5:0]   offset;
    logic [5:0]   delay;
  } asd_cfg_t;

  // one decoded audio word
  typedef struct packed {
    logic [2:0]  chan;
    logic        first;
    logic [31:0] data;
  } asd_word_t;

  // the three link lines
  typedef struct packed {
    logic sd;
    logic ws;
    logic bclk;
  } asd_link_t;

endpackage

// File: rtl/asd_pin_sync.sv
// three flop synchroniser with agreement filter for the link lines
`timescale 1ns/1ps
`default_nettype none
module asd_pin_sync #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out
);
  logic [W-1:0] s1_q;   // first stage, read only by s2
  logic [W-1:0] s2_q;   // second stage
  logic [W-1:0] s3_q;   // third stage
  logic [W-1:0] agree;  // bits where stages two and three match

  assign agree = ~(s2_q ^ s3_q);

  // shift chain, output takes a bit only once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q    <= '0;
      s2_q    <= '0;
      s3_q    <= '0;
      pin_out <= '0;
    end else begin
      s1_q    <= pin_in;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      pin_out <= (pin_out & ~agree) | (s3_q & agree);
    end
  end
endmodule // asd_pin_sync
`default_nettype wire

// File: rtl/asd_word_shift.sv
// bit history of the data line and word formatter
`timescale 1ns/1ps
`default_nettype none
module asd_word_shift #(
  parameter int W = 32
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         shift_en,
  input  wire logic         bit_in,
  input  wire logic [5:0]   wlen,
  input  wire logic         lsb_first,
  output logic      [W-1:0] word
);
  logic [W-1:0] hist_q;  // newest bit in bit 0
  logic         sign;    // last bit of the word when read in order

  // history shifts on every sampling edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hist_q <= '0;
    end else if (shift_en) begin
      hist_q <= {hist_q[W-2:0], bit_in};
    end
  end

  // pick the newest wlen bits, reorder, sign extend
  always_comb begin
    sign = lsb_first ? hist_q[0] : hist_q[int'(wlen) - 1];
    word = '0;
    for (int i = 0; i < W; i++) begin
      if (i < int'(wlen)) begin
        word[i] = lsb_first ? hist_q[int'(wlen) - 1 - i] : hist_q[i];
      end else begin
        word[i] = sign;
      end
    end
  end
endmodule // asd_word_shift
`default_nettype wire

// File: rtl/asd_frame_decoder.sv
// serial audio frame decoder with apb registers
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "asd_defines.svh"

module asd_frame_decoder
  import asd_pkg::*;
#(
  parameter int WORD_W = 32
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        bclk_pin,
  input  wire logic        ws_pin,
  input  wire logic        sd_pin,
  output logic             word_valid,
  output var asd_word_t    word_out
);


  // helpers

  // true for every mapped register offset
  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == `ASD_OFF_CTRL) || (a == `ASD_OFF_LEN) ||
               (a == `ASD_OFF_STAT) || (a == `ASD_OFF_DATA);
  endfunction

  // clamp channel length, word length and offset into a legal set
  function automatic logic [31:0] len_fix(input logic [31:0] raw);
    logic [5:0] c;
    logic [5:0] w;
    logic [5:0] o;
    logic [5:0] d;
    c = raw[`ASD_LEN_CLEN_LO +: `ASD_LEN_FW];
    w = raw[`ASD_LEN_WLEN_LO +: `ASD_LEN_FW];
    o = raw[`ASD_LEN_OFF_LO +: `ASD_LEN_FW];
    d = raw[`ASD_LEN_DLY_LO +: `ASD_LEN_FW];
    // zero or oversize channel length falls back to a full slot
    if (c == 6'h00 || c > `ASD_SLOT_MAX) begin
      c = `ASD_SLOT_MAX;
    end
    // word of one bit at least and no longer than the block
    if (w == 6'h00) begin
      w = 6'h01;
    end
    if (w > c) begin
      w = c;
    end
    // offset never pushes the word past the block end
    if (o > 6'(c - w)) begin
      o = 6'(c - w);
    end
    len_fix = {2'h0, d, 2'h0, o, 2'h0, w, 2'h0, c};
  endfunction


  // registers and configuration
  logic [31:0]  ctrl_q;      // control register
  logic [31:0]  len_q;       // length register, always legal
  asd_cfg_t     cfg;         // decoded settings
  logic         wr_en;       // write taken this cycle
  logic         rd_data_en;  // data register read taken
  logic         rearm;       // drop alignment

  assign wr_en      = psel & penable & pwrite & addr_hit(paddr);
  assign rd_data_en = psel & penable & ~pwrite & (paddr == `ASD_OFF_DATA);
  assign rearm      = (wr_en & (paddr == `ASD_OFF_CTRL)) | ~cfg.enable;

  // field split of both setting registers
  always_comb begin
    cfg.enable      = ctrl_q[`ASD_CTRL_EN];
    cfg.variant     = asd_variant_t'(ctrl_q[`ASD_CTRL_VAR_LO +: 2]);
    cfg.ws_inv      = ctrl_q[`ASD_CTRL_WS_INV];
    cfg.sample_fall = ctrl_q[`ASD_CTRL_FALL];
    cfg.act_low     = ctrl_q[`ASD_CTRL_ACT_LOW];
    cfg.lsb_first   = ctrl_q[`ASD_CTRL_LSB];
    cfg.right_first = ctrl_q[`ASD_CTRL_RIGHT1ST];
    cfg.nch_m1      = ctrl_q[`ASD_CTRL_NCH_LO +: 3];
    cfg.clen        = len_q[`ASD_LEN_CLEN_LO +: `ASD_LEN_FW];
    cfg.wlen        = len_q[`ASD_LEN_WLEN_LO +: `ASD_LEN_FW];
    cfg.offset      = len_q[`ASD_LEN_OFF_LO +: `ASD_LEN_FW];
    cfg.delay       = len_q[`ASD_LEN_DLY_LO +: `ASD_LEN_FW];
  end

  // software writes to the setting registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `ASD_CTRL_RST;
      len_q  <= `ASD_LEN_RST;
    end else if (wr_en) begin
      if (paddr == `ASD_OFF_CTRL) begin
        ctrl_q <= pwdata & `ASD_CTRL_MASK;
      end
      if (paddr == `ASD_OFF_LEN) begin
        len_q <= len_fix(pwdata);
      end
    end
  end


  // link sampling
  asd_link_t    link;        // filtered link lines
  logic         bclk_prev_q; // clock level one cycle ago
  logic         sample_en;   // chosen clock edge seen
  logic         bit_val;     // data bit after polarity
  logic [WORD_W-1:0] shaped; // formatted word from history

  // all three lines pass the same synchroniser so they stay aligned
  asd_pin_sync #(
    .W (3)
  ) u_sync (
    .clk     (pclk),
    .rst_n   (presetn),
    .pin_in  ({sd_pin, ws_pin, bclk_pin}),
    .pin_out (link)
  );

  // previous clock level for edge finding
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bclk_prev_q <= 1'b0;
    end else begin
      bclk_prev_q <= link.bclk;
    end
  end

  // pick rising or falling edge, then apply data polarity
  assign sample_en = cfg.sample_fall ? (bclk_prev_q & ~link.bclk)
                                     : (~bclk_prev_q & link.bclk);
  assign bit_val   = link.sd ^ cfg.act_low;

  // running history and word formatter
  asd_word_shift #(
    .W (WORD_W)
  ) u_shift (
    .clk       (pclk),
    .rst_n     (presetn),
    .shift_en  (sample_en),
    .bit_in    (bit_val),
    .wlen      (cfg.wlen),
    .lsb_first (cfg.lsb_first),
    .word      (shaped)
  );


  // word select history
  logic         ws_last_q;   // ws at previous sampling edge
  logic         ws_dly_q;    // ws two sampling edges back
  logic [1:0]   prime_q;     // history valid flags
  logic         eff_ws;      // ws aligned to the data word
  logic         eff_chg;     // slot boundary at this edge
  logic         fs_edge;     // selected frame sync edge
  logic         is_tdm;      // frame sync mode

  // history of ws seen at sampling edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ws_last_q <= 1'b0;
      ws_dly_q  <= 1'b0;
      prime_q   <= 2'h0;
    end else if (sample_en) begin
      ws_last_q <= link.ws;
      ws_dly_q  <= ws_last_q;
      prime_q   <= {prime_q[0], 1'b1};
    end
  end

  // i2s looks at ws one edge late, so its first bit is one clock after
  assign is_tdm  = (cfg.variant == asd_tdm_format);
  assign eff_ws  = (cfg.variant == asd_i2s_format) ? ws_last_q : link.ws;
  assign eff_chg = (cfg.variant == asd_i2s_format) ?
                   (prime_q[1] & (ws_last_q != ws_dly_q)) :
                   (prime_q[0] & (link.ws != ws_last_q));
  // normal polarity frames start on rising sync, inverted on falling
  assign fs_edge = prime_q[0] & (link.ws != ws_last_q) &
                   (link.ws == ~cfg.ws_inv);


  // slot tracker
  asd_state_t   state_q;     // alignment state
  logic [5:0]   pos_q;       // bits already seen in this slot
  logic [5:0]   dly_q;       // remaining channel delay bits
  logic [2:0]   chan_q;      // channel of the running slot
  logic [5:0]   off_used;    // offset that applies to the variant
  logic [5:0]   cap_end;     // position of the word's last bit
  logic [5:0]   cur_pos;     // position of the bit at this edge
  logic [2:0]   slot_chan;   // channel of the bit at this edge
  logic         rj_hit;      // right aligned word complete
  logic         lj_hit;      // word complete at this edge
  logic         tdm_hit;     // tdm word complete at this edge

  // offset applies to left aligned and tdm only
  assign off_used  = (cfg.variant == asd_left_aligned_format || is_tdm) ?
                     cfg.offset : 6'h00;
  assign cap_end   = 6'(off_used + cfg.wlen - 6'h01);
  assign cur_pos   = eff_chg ? 6'h00 : pos_q;
  // normal polarity: level zero is left, one is right
  assign slot_chan = eff_chg ? {2'h0, eff_ws ^ cfg.ws_inv} : chan_q;

  // left aligned and i2s: word ends at a fixed place, later bits ignored
  assign lj_hit  = sample_en & ~is_tdm & (cfg.variant != asd_right_aligned_format) &
                   (state_q == asd_st_active || eff_chg) &
                   (cur_pos == cap_end);
  // right aligned: at the slot boundary take the newest bits backwards
  assign rj_hit  = sample_en & (cfg.variant == asd_right_aligned_format) &
                   (state_q == asd_st_active) & eff_chg &
                   (pos_q >= cfg.wlen);
  // tdm: word sits offset bits into each block once the delay ran out
  assign tdm_hit = sample_en & is_tdm & ~fs_edge & (state_q == asd_st_active) &
                   (dly_q == 6'h00) & (pos_q == cap_end);

  // alignment state, slot and block counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= asd_st_unaligned;
      pos_q   <= 6'h00;
      dly_q   <= 6'h00;
      chan_q  <= 3'h0;
    end else if (rearm) begin
      state_q <= asd_st_unaligned;
      pos_q   <= 6'h00;
      dly_q   <= 6'h00;
      chan_q  <= 3'h0;
    end else if (sample_en) begin
      case (state_q)
        // nothing counts until a boundary or sync edge is seen
        asd_st_unaligned: begin
          if (is_tdm ? fs_edge : eff_chg) begin
            state_q <= asd_st_active;
            pos_q   <= is_tdm ? 6'h00 : 6'h01;
            dly_q   <= cfg.delay;
            chan_q  <= is_tdm ? 3'h0 : slot_chan;
          end
        end
        // counting inside slots or blocks
        asd_st_active, asd_st_done: begin
          if (is_tdm && fs_edge) begin
            state_q <= asd_st_active;
            pos_q   <= 6'h00;
            dly_q   <= cfg.delay;
            chan_q  <= 3'h0;
          end else if (is_tdm) begin
            if (state_q == asd_st_done) begin
              pos_q <= 6'h00;  // idle until next frame sync
            end else if (dly_q != 6'h00) begin
              dly_q <= 6'(dly_q - 6'h01);
            end else if (pos_q == 6'(cfg.clen - 6'h01)) begin
              pos_q <= 6'h00;
              if (chan_q == cfg.nch_m1) begin
                state_q <= asd_st_done;
              end else begin
                chan_q <= 3'(chan_q + 3'h1);
              end
            end else begin
              pos_q <= 6'(pos_q + 6'h01);
            end
          end else if (eff_chg) begin
            state_q <= asd_st_active;
            pos_q   <= 6'h01;
            chan_q  <= slot_chan;
          end else if (pos_q != 6'h3F) begin
            pos_q <= 6'(pos_q + 6'h01);
          end
        end
        default: begin
          state_q <= asd_st_unaligned;
        end
      endcase
    end
  end


  // word output
  logic         pend_q;      // word ends at last edge, history ready now
  logic [2:0]   pend_chan_q; // channel of the pending word
  logic         emit;        // word goes out this cycle
  logic [2:0]   emit_chan;   // channel of that word
  logic         emit_first;  // that channel leads the frame

  // forward and left aligned words wait one cycle for the history shift
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q      <= 1'b0;
      pend_chan_q <= 3'h0;
    end else begin
      pend_q      <= (lj_hit | tdm_hit) & ~rearm;
      pend_chan_q <= is_tdm ? chan_q : slot_chan;
    end
  end

  // right aligned words use the history before this edge's bit
  assign emit       = pend_q | (rj_hit & ~rearm);
  assign emit_chan  = pend_q ? pend_chan_q : chan_q;
  assign emit_first = is_tdm ? (emit_chan == 3'h0) :
                      (emit_chan == {2'h0, cfg.right_first});

  // registered word with its channel and a one cycle valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_valid <= 1'b0;
      word_out   <= '0;
    end else begin
      word_valid <= emit;
      if (emit) begin
        word_out.chan  <= emit_chan;
        word_out.first <= emit_first;
        word_out.data  <= shaped;
      end
    end
  end


  // status
  logic         new_q;       // unread word waiting
  logic [15:0]  cnt_q;       // decoded word count, wraps
  logic [31:0]  stat;        // status register image

  // new flag: a fresh word wins over the clearing read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      new_q <= 1'b0;
      cnt_q <= 16'h0000;
    end else begin
      if (word_valid) begin
        new_q <= 1'b1;
        cnt_q <= 16'(cnt_q + 16'h0001);
      end else if (rd_data_en) begin
        new_q <= 1'b0;
      end
    end
  end

  // status image
  always_comb begin
    stat = 32'h0000_0000;
    stat[`ASD_STAT_ALIGNED]       = (state_q != asd_st_unaligned);
    stat[`ASD_STAT_NEW]           = new_q;
    stat[`ASD_STAT_CHAN_LO +: 3]  = word_out.chan;
    stat[`ASD_STAT_FIRST]         = word_out.first;
    stat[`ASD_STAT_CNT_LO +: 16]  = cnt_q;
  end


  // apb read path, data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      case (paddr)
        `ASD_OFF_CTRL: prdata <= ctrl_q;
        `ASD_OFF_LEN:  prdata <= len_q;
        `ASD_OFF_STAT: prdata <= stat;
        `ASD_OFF_DATA: prdata <= word_out.data;
        default:       prdata <= 32'h0000_0000;
      endcase
    end
  end

  // zero wait states; unmapped offsets answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_hit(paddr);

endmodule // asd_frame_decoder
`default_nettype wire

// File: test/asd_monitor.sv
// port checker for the audio frame decoder
`timescale 1ns/1ps
`default_nettype none
module asd_monitor
  import asd_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        word_valid,
  input wire asd_word_t   word_out
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // zero wait states
  a_ready_high: assert property (pready) else $error("pready low");
  // unmapped access answers with an error
  a_err_unmapped: assert property (psel && penable && paddr > 12'h00C |-> pslverr)
    else $error("no slave error");
  // error only inside an access phase
  a_err_quiet: assert property (!(psel && penable) |-> !pslverr)
    else $error("stray slave error");
  // read data stays after the access
  a_rdata_hold: assert property (psel && penable && !pwrite |=> $stable(prdata))
    else $error("read data moved");
  // unmapped reads give zero
  a_rdata_zero: assert property (psel && penable && !pwrite && paddr > 12'h00C
    |-> prdata == 32'h0) else $error("unmapped read not zero");
  // one pulse per word, never two close together
  a_valid_pulse: assert property (word_valid |=> !word_valid [*8])
    else $error("word pulse too long");
  // word holds between pulses
  a_word_hold: assert property (!word_valid |-> $stable(word_out))
    else $error("word moved without pulse");
  // no channel above one opens a frame
  a_first_chan: assert property (word_valid && word_out.chan > 3'h1
    |-> !word_out.first) else $error("bad first flag");
endmodule // asd_monitor

bind asd_frame_decoder asd_monitor u_asd_monitor (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .word_valid, .word_out);
`default_nettype wire

// File: test/asd_link_model.sv
// serial audio transmitter model driving clock, word select and data
`timescale 1ns/1ps
`default_nettype none
module asd_link_model
  import asd_pkg::*;
(
  input  wire logic             run,  // send frames while high
  input  var asd_cfg_t          cfg,  // line format
  input  wire logic [7:0][31:0] wd,   // word per channel
  output var asd_link_t         link  // the three lines
);
  int   cl, wl, st, k, ch;  // slot geometry
  logic t, w;               // tdm flag, word select level

  // lines change on the idle edge, the decoder samples on the other
  task automatic bit_out(input logic w_i, input logic d_i);
    link.ws <= w_i ^ cfg.ws_inv;
    link.sd <= d_i ^ cfg.act_low;
    link.bclk <= cfg.sample_fall;
    #62.5;
    link.bclk <= ~cfg.sample_fall;
    #62.5;
  endtask

  // frames back to back while run is high, clock still otherwise
  initial begin
    link = '0;
    forever begin
      wait (run);
      while (run) begin
        t = cfg.variant == asd_tdm_format;
        cl = cfg.clen;
        wl = cfg.wlen;
        // tdm sync bit, then the channel delay
        if (t) for (int b = -1; b < int'(cfg.delay); b++)
          bit_out(b < 0, b[0]);
        for (int s = 0; s <= (t ? int'(cfg.nch_m1) : 1); s++) begin
          ch = t ? s : s ^ cfg.right_first;
          for (int b = 0; b < cl; b++) begin
            st = cfg.variant == asd_right_aligned_format ? cl - wl :
              cfg.variant == asd_i2s_format ? 0 : cfg.offset;
            k = b - st;
            w = !t && (ch[0] ^ (cfg.variant == asd_i2s_format && b == cl - 1));
            bit_out(w, k >= 0 && k < wl ?
              wd[ch][cfg.lsb_first ? k : wl - 1 - k] : ~b[0]);
          end
        end
      end
    end
  end
endmodule // asd_link_model
`default_nettype wire

// File: test/asd_frame_decoder_tb.sv
// self-checking bench for the audio frame decoder
`timescale 1ns/1ps
`default_nettype none
module asd_frame_decoder_tb import asd_pkg::*;;
  logic             pclk = 1'b0;
  logic             presetn = 1'b0;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [11:0]      paddr = 12'h000;
  logic [31:0]      pwdata = 32'h0;
  logic [31:0]      prdata, r, lv;
  logic             pready, pslverr, word_valid, err;
  asd_word_t        word_out;
  asd_link_t        link;
  asd_cfg_t         cfg = '0;        // active line setup
  asd_cfg_t         cs [6];          // stream cases
  logic [7:0][31:0] wd = '0;         // sent word per channel
  logic             run = 1'b0;
  logic [31:0]      seed = 32'h0000_004E;
  int               n_fail = 0, n_checks = 0, n_words, n_tot = 0, fb;

  // system clock
  initial forever #4 pclk = ~pclk;

  asd_frame_decoder u_asd_frame_decoder (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .bclk_pin(link.bclk), .ws_pin(link.ws),
    .sd_pin(link.sd), .word_valid, .word_out);
  asd_link_model u_asd_link_model (.run, .cfg, .wd, .link);

  // xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // sign extension from the word length
  function automatic logic [31:0] sext(logic [31:0] v, logic [5:0] n);
    for (int i = 0; i < 32; i++) if (i >= n) v[i] = v[n-1];
    return v;
  endfunction

  // expected readback of the length register
  function automatic logic [31:0] clamp(logic [31:0] v);
    logic [5:0] c, w, o;
    c = v[5:0];
    w = v[13:8];
    o = v[21:16];
    if (c == 6'h00 || c > 6'h20) c = 6'h20;
    if (w == 6'h00) w = 6'h01;
    if (w > c) w = c;
    if (o > c - w) o = c - w;
    return {2'h0, v[29:24], 2'h0, o, 2'h0, w, 2'h0, c};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, want, seen);
    end
  endtask

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // each emitted word must match what was sent on its channel
  always @(posedge pclk) if (word_valid === 1'b1) begin
    n_words++;
    lv = sext(wd[word_out.chan], cfg.wlen);
    check("chan", 32'(word_out.chan <= cfg.nch_m1), 32'h1);
    check("word", word_out.data, lv);
    check("first", 32'(word_out.first), 32'(word_out.chan ==
      (cfg.variant == asd_tdm_format ? 3'h0 : {2'h0, cfg.right_first})));
  end

  task automatic run_case(input asd_cfg_t c);
    cfg = c;
    for (int i = 0; i < 8; i++) wd[i] = rnd();
    apb(1'b1, 12'h000, {21'h0, c.nch_m1, c.right_first, c.lsb_first, c.act_low,
      c.sample_fall, c.ws_inv, c.variant, c.enable});
    apb(1'b1, 12'h004, {2'h0, c.delay, 2'h0, c.offset, 2'h0, c.wlen, 2'h0, c.clen});
    fb = c.variant == asd_tdm_format ? 1 + c.delay + (c.nch_m1 + 1) * c.clen : 2 * c.clen;
    n_words = 0;
    run = 1'b1;
    #(3 * fb * 125);
    run = 1'b0;
    #(fb * 125 + 800);
    @(posedge pclk);
    n_tot += n_words;
    check("count", 32'(c.enable ? n_words > c.nch_m1 : n_words == 0), 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    check("stat", r & 32'hFFFF_0003, {n_tot[15:0], 14'h0, c.enable, c.enable});
    apb(1'b0, 12'h00C, 32'h0);
    check("data", r, lv);
    apb(1'b0, 12'h008, 32'h0);
    check("new", 32'(r[1]), 32'h0);
  endtask

  task automatic print_verdict();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog
  initial begin
    #400000;
    n_fail++;
    print_verdict();
  end

  initial begin
    // head byte: enable, variant, inverted ws, falling, active low, lsb, right first
    cs[0] = {8'h00, 3'h1, 6'h20, 6'h10, 6'h00, 6'h00};  // disabled
    cs[1] = {8'h80, 3'h1, 6'h20, 6'h10, 6'h00, 6'h00};  // i2s
    cs[2] = {8'hB3, 3'h1, 6'h20, 6'h0C, 6'h03, 6'h00};  // left aligned with offset
    cs[3] = {8'hCC, 3'h1, 6'h20, 6'h14, 6'h00, 6'h00};  // right aligned
    cs[4] = {8'hE0, 3'h7, 6'h08, 6'h05, 6'h02, 6'h03};  // tdm eight channels
    cs[5] = {8'hFE, 3'h2, 6'h06, 6'h06, 6'h00, 6'h00};  // tdm, all options but right first turned
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0);
    check("ctrl reset", r, 32'h0000_0100);
    apb(1'b0, 12'h004, 32'h0);
    check("len reset", r, 32'h0000_1020);
    apb(1'b1, 12'h008, 32'hFFFF_FFFF);
    apb(1'b0, 12'h008, 32'h0);
    check("stat ro", r, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped", r, 32'h0);
    check("slverr", 32'(err), 32'h1);
    apb(1'b1, 12'h000, 32'hFFFF_FFFF);
    apb(1'b0, 12'h000, 32'h0);
    check("ctrl mask", r, 32'h0000_07FF);
    $display("register test done");
    for (int k = 0; k < 12; k++) begin
      lv = k == 0 ? 32'h0 : k == 1 ? 32'h0005_0C0A : rnd() & 32'h3F3F_3F3F;
      apb(1'b1, 12'h004, lv);
      apb(1'b0, 12'h004, 32'h0);
      check("len clamp", r, clamp(lv));
    end
    $display("length test done");
    lv = 32'h0;
    foreach (cs[k]) begin
      run_case(cs[k]);
      $display("stream test %0d done", k);
    end
    print_verdict();
  end
endmodule // asd_frame_decoder_tb
`default_nettype wire
